// *** shared/uoe_pkg.sv ***
/*
  constants for the usb otg status and bus event block: register offsets,
  field positions, reset values and timing counts.
  assumes a 250 mhz pclk and a 32-bit apb register bus.
*/
`default_nettype none
package uoe_pkg;
  // clock
  localparam int CLK_PERIOD_PS = 4000;
  // documented times in their own units
  localparam int T_BUS_EVT_NS  = 2500;  // attach, resume, reset hold time
  localparam int T_LINE_MS     = 1;     // line state debounce
  localparam int T_SLEEP_MS    = 3;     // idle before sleep
  // derived cycle counts, least times rounded up
  localparam int CYC_BUS_EVT   = (T_BUS_EVT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // reckoned per millisecond first: three ms in picoseconds would overflow an int
  localparam int CYC_PER_MS    = (1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_LINE_MS   = T_LINE_MS * CYC_PER_MS;
  localparam int CYC_SLEEP     = T_SLEEP_MS * CYC_PER_MS;
  localparam int CNT_W         = 20;    // holds the sleep count

  // register byte offsets
  localparam logic [7:0] OFS_OTG_CHG    = 8'h10;
  localparam logic [7:0] OFS_OTG_STAT   = 8'h18;
  localparam logic [7:0] OFS_OTG_CTL    = 8'h1C;
  localparam logic [7:0] OFS_BUS_ISTAT  = 8'h80;
  localparam logic [7:0] OFS_BUS_IEN    = 8'h84;

  // otg status and change flag fields
  localparam int B_ID     = 7;
  localparam int B_MS     = 6;
  localparam int B_LINE   = 5;
  localparam int B_BSV    = 3;
  localparam int B_BSE    = 2;
  localparam int B_AVV    = 0;
  localparam logic [7:0] OTG_STAT_MASK = 8'hED;

  // otg control fields
  localparam int B_DPH    = 7;
  localparam int B_DMH    = 6;
  localparam int B_DPL    = 5;
  localparam int B_DML    = 4;
  localparam int B_VBON   = 3;
  localparam int B_OTGEN  = 2;
  localparam int B_VBCHG  = 1;
  localparam int B_VBDIS  = 0;

  // bus event flag fields
  localparam int B_STALL  = 7;
  localparam int B_ATTACH = 6;
  localparam int B_RESUME = 5;
  localparam int B_SLEEP  = 4;
  localparam int B_TOKEN_COMPLETE  = 3;
  localparam int B_SOF    = 2;
  localparam int B_ERROR  = 1;
  localparam int B_RESET  = 0;

  // reset values
  localparam logic [7:0] RST_OTG_CTL = 8'h00;
  localparam logic [7:0] RST_ISTAT   = 8'h00;
  localparam logic [7:0] RST_IEN     = 8'h00;
  localparam logic [7:0] RST_OTG_CHG = 8'h00;
endpackage : uoe_pkg
`default_nettype wire

// *** shared/uoe_line_if.sv ***
/*
  carrier between the register top and the line monitor: clean line levels
  in, bus event pulses and debounced line state out.
  assumes both ends run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface uoe_line_if;
  logic dp;           // filtered d+ level
  logic dm;           // filtered d- level
  logic host_mode;    // controller in host mode
  logic attach_p;     // attach seen, one cycle
  logic resume_p;     // k held, one cycle
  logic reset_p;      // se0 held, one cycle
  logic sleep_p;      // idle held, one cycle
  logic line_stable;  // line state steady for the debounce time
  logic line_chg_p;   // debounced state differs from last one
  modport ctl (output dp, dm, host_mode,
               input attach_p, resume_p, reset_p, sleep_p, line_stable, line_chg_p);
  modport mon (input dp, dm, host_mode,
               output attach_p, resume_p, reset_p, sleep_p, line_stable, line_chg_p);
endinterface : uoe_line_if
`default_nettype wire

// *** rtl/uoe_line_mon.sv ***
/*
  line monitor: one saturating quiet counter measures how long the bus has
  held its present state and fires the timed bus events from it.
  assumes dp and dm are already synchronised to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module uoe_line_mon
  import uoe_pkg::*;
#(
  parameter int EVT_CYC   = CYC_BUS_EVT,  // 2.5 us hold
  parameter int LINE_CYC  = CYC_LINE_MS,  // 1 ms debounce
  parameter int SLEEP_CYC = CYC_SLEEP     // 3 ms idle
) (
  input  wire logic pclk,     // bus clock
  input  wire logic presetn,  // async reset, low
  uoe_line_if.mon   lif       // line levels and events
);
  logic [1:0]       state_ff;     // {dp,dm} last cycle
  logic [CNT_W-1:0] quiet_ff;     // cycles since last change
  logic [1:0]       last_deb_ff;  // last debounced state
  logic [1:0]       cur;
  logic             changed;
  logic             is_j;
  logic             is_k;
  logic             is_se0;

  // full-speed polarity: j is d+ high
  assign cur     = {lif.dp, lif.dm};
  assign changed = (cur != state_ff);
  assign is_j    = (cur == 2'b10);
  assign is_k    = (cur == 2'b01);
  assign is_se0  = (cur == 2'b00);

  // quiet counter, restarted by any transition; saturates so events fire once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= 2'h0;
      quiet_ff <= '0;
    end else begin
      state_ff <= cur;
      if (changed) begin
        quiet_ff <= '0;
      end else if (quiet_ff != {CNT_W{1'b1}}) begin
        quiet_ff <= quiet_ff + 1'b1;
      end
    end
  end

  // timed events fire on the one cycle the count passes its figure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lif.attach_p <= 1'b0;
      lif.resume_p <= 1'b0;
      lif.reset_p  <= 1'b0;
      lif.sleep_p  <= 1'b0;
    end else begin
      lif.attach_p <= !changed && lif.host_mode && !is_se0
                      && quiet_ff == CNT_W'(EVT_CYC - 1);
      lif.resume_p <= !changed && is_k && quiet_ff == CNT_W'(EVT_CYC - 1);
      // once per se0 episode: the count only passes the figure again after a change
      lif.reset_p  <= !changed && is_se0 && quiet_ff == CNT_W'(EVT_CYC - 1);
      lif.sleep_p  <= !changed && is_j && quiet_ff == CNT_W'(SLEEP_CYC - 1);
    end
  end

  // debounced line state and its change flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lif.line_stable <= 1'b0;
      lif.line_chg_p  <= 1'b0;
      last_deb_ff     <= 2'h0;
    end else begin
      lif.line_stable <= !changed && quiet_ff >= CNT_W'(LINE_CYC - 1);
      lif.line_chg_p  <= 1'b0;
      if (!changed && quiet_ff == CNT_W'(LINE_CYC - 1)) begin
        last_deb_ff <= cur;
        lif.line_chg_p <= (cur != last_deb_ff);
      end
    end
  end
endmodule // uoe_line_mon
`default_nettype wire

// *** rtl/uoe_otg_top.sv ***
/*
  usb otg status, pull and vbus control, and bus event flags behind an apb
  slave. holds the otg change flags, otg status, otg control, bus event
  flags and bus event enables.
  assumes the rest of the controller delivers one-cycle event pulses on
  pclk, and that cable pins and comparators are asynchronous to pclk.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module uoe_otg_top
  import uoe_pkg::*;
#(
  parameter int LINE_CYC  = CYC_LINE_MS,  // 1 ms in cycles
  parameter int SLEEP_CYC = CYC_SLEEP     // 3 ms in cycles
) (
  input  wire logic        pclk,                // bus clock, 250 mhz
  input  wire logic        presetn,             // async reset, low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error, unmapped
  input  wire logic        usb_dp_in,           // d+ receiver level
  input  wire logic        usb_dm_in,           // d- receiver level
  input  wire logic        cable_identity,      // id pin, high no cable or b
  input  wire logic        b_session_valid,     // comparator
  input  wire logic        b_session_end,       // comparator
  input  wire logic        a_vbus_valid,        // comparator
  input  wire logic        ctrl_enable,         // controller enabled
  input  wire logic        host_mode,           // controller in host mode
  input  wire logic        stall_evt,           // stall sent or seen
  input  wire logic        token_complete,      // token finished
  input  wire logic        sof_token_evt,       // sof token received
  input  wire logic        sof_threshold_evt,   // host sof threshold hit
  input  wire logic        error_status_evt,    // any error status set
  output logic             stat_advance,        // clear or load endpoint status
  output logic             dplus_pullup_en,     // d+ pull-up
  output logic             dminus_pullup_en,    // d- pull-up
  output logic             dplus_pulldown_en,   // d+ pull-down
  output logic             dminus_pulldown_en,  // d- pull-down
  output logic             vbus_drive_on,       // vbus supply on
  output logic             vbus_charge,         // vbus charge resistor
  output logic             vbus_discharge,      // vbus discharge resistor
  output logic             bus_event_irq        // enabled bus event pending
);
  localparam int NPIN = 6;

  uoe_line_if lif ();

  logic [NPIN-1:0] sync1_ff;        // first stage, read by second only
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] sync3_ff;
  logic [NPIN-1:0] pin_ff;          // accepted pin levels
  logic [7:0]      otg_ctl_ff;      // pull and vbus control
  logic [7:0]      otg_chg_ff;      // otg change flags
  logic [7:0]      istat_ff;        // bus event flags
  logic [7:0]      ien_ff;          // bus event enables
  logic [NPIN-1:0] prev_pin_ff;     // levels for change detection
  logic [CNT_W-1:0] ms_cnt_ff;      // millisecond divider
  logic            ms_lvl_ff;       // toggles every millisecond
  logic            ms_tick;
  logic            wr_en;
  logic            rd_setup;
  logic [7:0]      wmask;
  logic [7:0]      nxt_istat;
  logic [7:0]      istat_set;
  logic [7:0]      chg_set;
  logic [7:0]      stat_view;
  logic            id_s;
  logic            bsv_s;
  logic            bse_s;
  logic            avv_s;

  // three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pin_ff   <= '0;
    end else begin
      sync1_ff <= {usb_dp_in, usb_dm_in, cable_identity, b_session_valid, b_session_end, a_vbus_valid};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < NPIN; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          pin_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  assign id_s  = pin_ff[3];
  assign bsv_s = pin_ff[2];
  assign bse_s = pin_ff[1];
  assign avv_s = pin_ff[0];

  // line monitor sees the filtered data lines
  assign lif.dp        = pin_ff[5];
  assign lif.dm        = pin_ff[4];
  assign lif.host_mode = host_mode;

  uoe_line_mon #(
    .EVT_CYC   (CYC_BUS_EVT),
    .LINE_CYC  (LINE_CYC),
    .SLEEP_CYC (SLEEP_CYC)
  ) u_line_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .lif     (lif.mon)
  );

  // free-running millisecond divider
  assign ms_tick = (ms_cnt_ff == CNT_W'(LINE_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= '0;
      ms_lvl_ff <= 1'b0;
    end else if (ms_tick) begin
      ms_cnt_ff <= '0;
      ms_lvl_ff <= !ms_lvl_ff;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 1'b1;
    end
  end

  // apb decode: write lands at the access edge that sees pready high
  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign wmask    = pwdata[7:0];  // upper write bits dropped

  // live otg status view
  always_comb begin
    stat_view         = 8'h00;
    stat_view[B_ID]   = id_s;
    stat_view[B_MS]   = ms_lvl_ff;
    stat_view[B_LINE] = lif.line_stable;
    stat_view[B_BSV]  = bsv_s;
    stat_view[B_BSE]  = bse_s;
    stat_view[B_AVV]  = avv_s;
  end

  // otg change sources: edges of the accepted levels, the millisecond tick and the line change pulse
  always_comb begin
    chg_set         = 8'h00;
    chg_set[B_ID]   = id_s  ^ prev_pin_ff[3];
    chg_set[B_MS]   = ms_tick;
    chg_set[B_LINE] = lif.line_chg_p;
    chg_set[B_BSV]  = bsv_s ^ prev_pin_ff[2];
    chg_set[B_BSE]  = bse_s ^ prev_pin_ff[1];
    chg_set[B_AVV]  = avv_s ^ prev_pin_ff[0];
  end

  // otg change flags, write one clears, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_chg_ff  <= RST_OTG_CHG;
      prev_pin_ff <= '0;
    end else begin
      prev_pin_ff <= pin_ff;
      if (wr_en && paddr == OFS_OTG_CHG) begin
        otg_chg_ff <= ((otg_chg_ff & ~wmask) | chg_set) & OTG_STAT_MASK;
      end else begin
        otg_chg_ff <= (otg_chg_ff | chg_set) & OTG_STAT_MASK;
      end
    end
  end

  // otg control, all eight bits writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_ctl_ff <= RST_OTG_CTL;
    end else if (wr_en && paddr == OFS_OTG_CTL) begin
      otg_ctl_ff <= wmask;
    end
  end

  // bus event enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff <= RST_IEN;
    end else if (wr_en && paddr == OFS_BUS_IEN) begin
      ien_ff <= wmask;
    end
  end

  // bus event sources
  always_comb begin
    istat_set           = 8'h00;
    istat_set[B_STALL]  = stall_evt;
    istat_set[B_ATTACH] = lif.attach_p && host_mode;
    istat_set[B_RESUME] = lif.resume_p;
    istat_set[B_SLEEP]  = lif.sleep_p;
    istat_set[B_TOKEN_COMPLETE]  = token_complete;
    istat_set[B_SOF]    = host_mode ? sof_threshold_evt
                                    : sof_token_evt;
    istat_set[B_ERROR]  = error_status_evt;
    istat_set[B_RESET]  = lif.reset_p;
  end

  // flags clear on a written one; a same-cycle event keeps the flag set
  always_comb begin
    nxt_istat = istat_ff | istat_set;
    if (wr_en && paddr == OFS_BUS_ISTAT) begin
      nxt_istat = (istat_ff & ~wmask) | istat_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff      <= RST_ISTAT;
      bus_event_irq <= 1'b0;
      stat_advance  <= 1'b0;
    end else begin
      istat_ff      <= nxt_istat;
      bus_event_irq <= |(nxt_istat & ien_ff);
      // endpoint status moves on when software retires a done token
      stat_advance  <= wr_en && paddr == OFS_BUS_ISTAT
                       && wmask[B_TOKEN_COMPLETE] && istat_ff[B_TOKEN_COMPLETE];
    end
  end

  // pull resistor selection; otg enable is ignored while the controller is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dplus_pullup_en    <= 1'b0;
      dminus_pullup_en   <= 1'b0;
      dplus_pulldown_en  <= 1'b0;
      dminus_pulldown_en <= 1'b0;
    end else if (ctrl_enable && otg_ctl_ff[B_OTGEN]) begin
      dplus_pullup_en    <= otg_ctl_ff[B_DPH];
      dminus_pullup_en   <= otg_ctl_ff[B_DMH];
      dplus_pulldown_en  <= otg_ctl_ff[B_DPL];
      dminus_pulldown_en <= otg_ctl_ff[B_DML];
    end else begin
      dplus_pullup_en    <= !host_mode;
      dminus_pullup_en   <= 1'b0;
      dplus_pulldown_en  <= host_mode && ctrl_enable;
      dminus_pulldown_en <= host_mode && ctrl_enable;
    end
  end

  // vbus controls follow their bits directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_drive_on  <= 1'b0;
      vbus_charge    <= 1'b0;
      vbus_discharge <= 1'b0;
    end else begin
      vbus_drive_on  <= otg_ctl_ff[B_VBON];
      vbus_charge    <= otg_ctl_ff[B_VBCHG];
      vbus_discharge <= otg_ctl_ff[B_VBDIS];
    end
  end

  // apb answer: data captured in setup, pready for exactly one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;  // upper bits always zero
      case (paddr)
        OFS_OTG_CHG:   prdata[7:0] <= otg_chg_ff;
        OFS_OTG_STAT:  prdata[7:0] <= stat_view;
        OFS_OTG_CTL:   prdata[7:0] <= otg_ctl_ff;
        OFS_BUS_ISTAT: prdata[7:0] <= istat_ff;
        OFS_BUS_IEN:   prdata[7:0] <= ien_ff;
        default:       pslverr     <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // uoe_otg_top
`default_nettype wire

// *** tb/uoe_cable_model.sv ***
/* far-side cable model: drives the data lines to j, k or se0, or lets them
   float to the pull level. assumes full-speed polarity. */
`timescale 1ns/1ps
`default_nettype none
module uoe_cable_model (
  input  wire logic [1:0] drive,    // 0 release, 1 j, 2 k, 3 se0
  input  wire logic       pull_up,  // d+ pull-up engaged
  output logic            dp,       // d+ level
  output logic            dm        // d- level
);
  // released lines settle to the pull level, never the last driven state
  always_comb begin
    case (drive)
      2'h1: {dp, dm} = 2'h2;
      2'h2: {dp, dm} = 2'h1;
      2'h3: {dp, dm} = 2'h0;
      default: {dp, dm} = {pull_up, 1'b0};
    endcase
  end
endmodule // uoe_cable_model
`default_nettype wire

// *** tb/uoe_otg_props.sv ***
/* port checker for the otg status block.
   assumes one pclk domain and binding onto uoe_otg_top. */
`timescale 1ns/1ps
`default_nettype none
module uoe_otg_props
  import uoe_pkg::*;
(
  input wire logic        pclk,               // clock
  input wire logic        presetn,            // reset, low
  input wire logic        psel,               // select
  input wire logic        penable,            // access
  input wire logic        pwrite,             // direction
  input wire logic [7:0]  paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        ctrl_enable,        // controller on
  input wire logic        host_mode,          // host
  input wire logic        stall_evt,          // stall
  input wire logic        sof_token_evt,      // sof token
  input wire logic        sof_threshold_evt,  // sof threshold
  input wire logic        error_status_evt,   // error
  input wire logic        stat_advance,       // status advance
  input wire logic        dplus_pullup_en,    // pull
  input wire logic        dminus_pullup_en,   // pull
  input wire logic        dplus_pulldown_en,  // pull
  input wire logic        dminus_pulldown_en, // pull
  input wire logic        vbus_drive_on,      // vbus
  input wire logic        vbus_charge,        // vbus
  input wire logic        vbus_discharge,     // vbus
  input wire logic        bus_event_irq       // irq
);
  logic [7:0] ien_ff;  // shadow of enables
  logic [7:0] ctl_ff;  // shadow of control
  logic       acc;     // completed write
  logic       oe;      // otg pulls in force
  logic       hp;      // enabled host
  logic       tclr;    // token flag cleared
  assign acc  = psel && penable && pready && pwrite;
  assign oe   = ctrl_enable && ctl_ff[B_OTGEN];
  assign hp   = ctrl_enable && host_mode;
  assign tclr = acc && paddr == OFS_BUS_ISTAT && pwdata[B_TOKEN_COMPLETE];
  // shadows follow completed writes only, as the slave does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff <= 8'h00;
      ctl_ff <= 8'h00;
    end else if (acc) begin
      if (paddr == OFS_BUS_IEN) ien_ff <= pwdata[7:0];
      if (paddr == OFS_OTG_CTL) ctl_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_reserved: assert property (s_setup |=> pready && prdata[31:8] == 24'h0 ##1 !pready)
    else $error("apb answer late or reserved bits set");
  // write data is gone from the bus two edges later, so compare with its past value
  a_vbus_follow: assert property (acc && paddr == OFS_OTG_CTL |-> ##2
    {vbus_drive_on, vbus_charge, vbus_discharge} == $past({pwdata[B_VBON], pwdata[B_VBCHG], pwdata[B_VBDIS]}, 2))
    else $error("vbus controls do not follow write");
  a_pull_otg: assert property ($past(oe) |->
    {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en} == $past(ctl_ff[7:4]))
    else $error("pulls differ from control bits");
  a_pull_default: assert property ($past(presetn) && !$past(oe) |-> dplus_pullup_en == !$past(host_mode)
    && !dminus_pullup_en && dplus_pulldown_en == $past(hp) && dminus_pulldown_en == $past(hp))
    else $error("default pulls wrong");
  a_stall_irq: assert property (stall_evt && ien_ff[B_STALL] |=> bus_event_irq)
    else $error("stall did not raise irq");
  a_sof_src: assert property ((host_mode ? sof_threshold_evt : sof_token_evt) && ien_ff[B_SOF] |=> bus_event_irq)
    else $error("sof did not raise irq");
  a_error_irq: assert property (error_status_evt && ien_ff[B_ERROR] |=> bus_event_irq)
    else $error("error did not raise irq");
  a_irq_masked: assert property (ien_ff == 8'h00 && $past(ien_ff) == 8'h00 && $past(ien_ff, 2) == 8'h00
    |-> !bus_event_irq)
    else $error("irq with all enables off");
  a_token_complete_adv: assert property (stat_advance |-> $past(tclr) || $past(tclr, 2))
    else $error("status advance without token clear");
endmodule // uoe_otg_props
bind uoe_otg_top uoe_otg_props u_props (.*);
`default_nettype wire

// *** tb/tb.sv ***
/* self-checking bench for uoe_otg_top over apb with a cable model.
   assumes shortened debounce and sleep counts; 2.5 us stays 625 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb
  import uoe_pkg::*;
;
  localparam int EV = 625;  // 2.5 us at 4 ns
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stat_advance, bus_event_irq, err;
  logic        usb_dp_in, usb_dm_in, cable_identity, b_session_valid, b_session_end, a_vbus_valid;
  logic        ctrl_enable, host_mode, stall_evt, token_complete, sof_token_evt, sof_threshold_evt;
  logic        error_status_evt, dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en;
  logic        vbus_drive_on, vbus_charge, vbus_discharge;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  drv;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_adv = 0;
  int          eb[5] = '{B_STALL, B_TOKEN_COMPLETE, B_SOF, B_SOF, B_ERROR};
  uoe_otg_top #(.LINE_CYC(50), .SLEEP_CYC(150)) u_dut (.*);
  uoe_cable_model u_cable (.drive(drv), .pull_up(dplus_pullup_en), .dp(usb_dp_in), .dm(usb_dm_in));
  always #2 pclk = ~pclk;
  // count endpoint status advances; the pulse stands one cycle only
  always @(posedge pclk) begin
    if (stat_advance === 1'b1) begin
      n_adv <= n_adv + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one-cycle pulse on event source k
  task automatic fire(input int k);
    {error_status_evt, sof_threshold_evt, sof_token_evt, token_complete, stall_evt} <= 5'h01 << k;
    @(posedge pclk);
    {error_status_evt, sof_threshold_evt, sof_token_evt, token_complete, stall_evt} <= 5'h00;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] outs();
    return {25'h0, vbus_drive_on, vbus_charge, vbus_discharge, dplus_pullup_en, dminus_pullup_en,
            dplus_pulldown_en, dminus_pulldown_en};
  endfunction
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // roughly five times the planned run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ctrl_enable, host_mode} = 5'h00;
    {cable_identity, b_session_valid, b_session_end, a_vbus_valid} = 4'h0;
    {error_status_evt, sof_threshold_evt, sof_token_evt, token_complete, stall_evt} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    drv = 2'h0;
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    rd(OFS_OTG_CTL, 32'hFFFFFFFF, 32'h0);
    rd(OFS_BUS_IEN, 32'hFFFFFFFF, 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_OTG_CTL, 32'hFFFFFFFF);
    rd(OFS_OTG_CTL, 32'hFFFFFFFF, 32'hFF);
    chk(outs(), 32'h78);
    ctrl_enable <= 1'b1;
    cyc(3);
    chk(outs(), 32'h7F);
    apb(1'b1, OFS_OTG_CTL, 32'h56);
    cyc(1);  // pulls are launched on the edge the task returns at
    chk(outs(), 32'h25);
    apb(1'b1, OFS_OTG_CTL, 32'h0);
    host_mode <= 1'b1;
    cyc(3);
    chk(outs(), 32'h03);
    host_mode <= 1'b0;
    cyc(3);
    chk(outs(), 32'h08);
    {cable_identity, b_session_valid, a_vbus_valid} <= 3'h7;
    apb(1'b1, OFS_OTG_STAT, 32'hFF);
    cyc(8);
    rd(OFS_OTG_STAT, 32'hFFFFFF8D, 32'h89);
    rd(OFS_OTG_CHG, 32'h8D, 32'h89);
    apb(1'b1, OFS_OTG_CHG, 32'hFF);
    rd(OFS_OTG_CHG, 32'h8D, 32'h0);
    {cable_identity, b_session_valid, b_session_end} <= 3'h1;
    cyc(8);
    rd(OFS_OTG_STAT, 32'h8D, 32'h05);
    apb(1'b1, OFS_BUS_IEN, 32'h8F);
    for (int k = 0; k < 5; k++) begin
      host_mode <= (k == 3);
      fire(k);
      rd(OFS_BUS_ISTAT, 32'h8F, 32'h1 << eb[k]);
      chk({31'h0, bus_event_irq}, 32'h1);
      apb(1'b1, OFS_BUS_ISTAT, 32'h1 << eb[k]);
      rd(OFS_BUS_ISTAT, 32'h8F, 32'h0);
      chk({31'h0, bus_event_irq}, 32'h0);
    end
    chk(n_adv, 32'h1);
    host_mode <= 1'b1;
    fire(2);
    rd(OFS_BUS_ISTAT, 32'h8F, 32'h0);
    apb(1'b1, OFS_BUS_IEN, 32'h0);
    fire(0);
    chk({31'h0, bus_event_irq}, 32'h0);
    rd(OFS_BUS_ISTAT, 32'h80, 32'h80);
    host_mode <= 1'b0;
    drv <= 2'h2;
    cyc(20);
    apb(1'b1, OFS_BUS_ISTAT, 32'hFF);
    cyc(EV - 150);
    rd(OFS_BUS_ISTAT, 32'h20, 32'h0);
    rd(OFS_OTG_STAT, 32'h20, 32'h20);
    rd(OFS_OTG_CHG, 32'h60, 32'h60);
    cyc(150);
    rd(OFS_BUS_ISTAT, 32'h60, 32'h20);
    drv <= 2'h1;
    cyc(10);
    rd(OFS_OTG_STAT, 32'h20, 32'h0);
    cyc(80);
    rd(OFS_BUS_ISTAT, 32'h10, 32'h0);
    drv <= 2'h2;
    cyc(5);
    drv <= 2'h1;
    cyc(100);
    rd(OFS_BUS_ISTAT, 32'h10, 32'h0);
    cyc(60);
    rd(OFS_BUS_ISTAT, 32'h10, 32'h10);
    host_mode <= 1'b1;
    cyc(EV);
    rd(OFS_BUS_ISTAT, 32'h40, 32'h40);
    apb(1'b1, OFS_BUS_ISTAT, 32'hFF);
    drv <= 2'h3;
    cyc(EV + 20);
    rd(OFS_BUS_ISTAT, 32'h01, 32'h01);
    apb(1'b1, OFS_BUS_ISTAT, 32'h01);
    cyc(EV + 20);
    rd(OFS_BUS_ISTAT, 32'h01, 32'h0);
    drv <= 2'h1;
    cyc(20);
    drv <= 2'h3;
    cyc(EV + 20);
    rd(OFS_BUS_ISTAT, 32'h01, 32'h01);
    conclude();
  end
endmodule // tb
`default_nettype wire
